// ---- design/tvsd_pkg.sv ----
// Purpose: Constants for the digital sound demodulator/decoder block
// Assumes: 40 MHz core clock, classic Wishbone register access
// Notes:   Word offsets are byte addresses
package tvsd_pkg;
	localparam int unsigned CLK_HZ        = 40000000;
	localparam int unsigned BIT_RATE_HZ   = 728000;
	localparam int unsigned WIN_MS        = 128;
	localparam int unsigned BIT_DIV       = CLK_HZ / BIT_RATE_HZ;
	localparam int unsigned WIN_CYC       = (CLK_HZ / 1000) * WIN_MS;
	localparam int unsigned ADC_W         = 8;
	localparam int unsigned NCO_W         = 24;
	localparam int unsigned GAIN_W        = 5;

	localparam logic [7:0] ADR_CTRL   = 8'h00;
	localparam logic [7:0] ADR_FREQ1  = 8'h04;
	localparam logic [7:0] ADR_FREQ2  = 8'h08;
	localparam logic [7:0] ADR_GAIN   = 8'h0C;
	localparam logic [7:0] ADR_STAT   = 8'h10;
	localparam logic [7:0] ADR_ERR    = 8'h14;
	localparam logic [7:0] ADR_IDENT  = 8'h18;

	// CTRL fields
	localparam int unsigned C_INSEL   = 0;
	localparam int unsigned C_AGC_EN  = 1;
	localparam int unsigned C_AM      = 2;
	localparam int unsigned C_DIG     = 3;
	localparam int unsigned C_ADAPT   = 4;
	localparam int unsigned C_TPOL    = 5;
	localparam int unsigned C_STD_LO  = 6;
	localparam int unsigned C_TC_LO   = 8;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0002;

	// STAT fields
	localparam int unsigned S_LOCK    = 0;
	localparam int unsigned S_VALID   = 1;
	localparam int unsigned S_MONO    = 2;

	// AGC thresholds on ADC magnitude
	localparam logic [6:0] AGC_HI      = 7'h70;
	localparam logic [6:0] AGC_LO      = 7'h30;
	localparam logic [9:0] AGC_SLOW    = 10'h3FF;
	localparam logic [4:0] GAIN_MAX    = 5'h1F;
	localparam logic [4:0] GAIN_MIN    = 5'h00;
	localparam logic [7:0] TUNE_RST    = 8'h80;

	// Frame decoding
	localparam logic [7:0] FAW         = 8'h4E;
	localparam int unsigned FRAME_BITS = 728;
	localparam logic [8:0] PRBS_SEED   = 9'h1FF;
	localparam logic [3:0] LOCK_NEED   = 4'h4;
	localparam logic [7:0] ERR_MAX     = 8'hFF;

	localparam int unsigned TC_FAST    = 1024;
	localparam int unsigned TC_MID     = 4096;
	localparam int unsigned TC_SLOW    = 16384;

	typedef enum logic [1:0] {
		TVSD_HUNT   = 2'b00,
		TVSD_SYNC   = 2'b01,
		TVSD_LOCKED = 2'b10
	} tvsd_fstate_t;
endpackage : tvsd_pkg

// ---- design/tvsd_core.sv ----
// Purpose: Sound-IF front end, mixers, demodulation, frame decoder
// Assumes: ADC samples and DQPSK symbols arrive synchronous to clk_i
// Notes:   Analog parts are represented by their digital control ports
//
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module tvsd_core
	import tvsd_pkg::*;
#(
	parameter int unsigned WIN_CYCLES = tvsd_pkg::WIN_CYC
) (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      ce_i,
	input  wire logic [31:0]               wb_adr_i,
	input  wire logic [31:0]               wb_dat_i,
	output logic      [31:0]               wb_dat_o,
	input  wire logic                      wb_we_i,
	input  wire logic [3:0]                wb_sel_i,
	input  wire logic                      wb_cyc_i,
	input  wire logic                      wb_stb_i,
	output logic                           wb_ack_o,
	input  wire logic [tvsd_pkg::ADC_W-1:0] adc_data_i,
	output logic                           if_select_o,
	output logic      [tvsd_pkg::GAIN_W-1:0] agc_gain_o,
	output logic      [tvsd_pkg::NCO_W-1:0] mixer1_word_o,
	output logic      [tvsd_pkg::NCO_W-1:0] mixer2_word_o,
	output logic                           demod_am_o,
	output logic                           deemph_adaptive_o,
	input  wire logic [1:0]                dqpsk_sym_i,
	input  wire logic                      dqpsk_sym_valid_i,
	input  wire logic signed [7:0]         carrier_err_i,
	input  wire logic signed [7:0]         timing_err_i,
	input  wire logic                      pilot_tone_i,
	input  wire logic                      dual_tone_i,
	input  wire logic                      parity_err_i,
	output logic                           digital_sound_serial_out_o,
	output logic                           bit_clock_o,
	output logic      [7:0]                oscillator_tuning_output_o
);
	import tvsd_pkg::*;

	// ----------------------------------------------------------------
	// Register file
	// ----------------------------------------------------------------
	logic [31:0] ctrl_q, ctrl_d;
	logic [NCO_W-1:0] f1_q, f1_d, f2_q, f2_d;
	logic [GAIN_W-1:0] fgain_q, fgain_d;
	logic [31:0] rdat_d, rdat_q;
	logic ack_q, ack_d;
	logic [7:0] err_q;
	logic lock_q, valid_q, mono_q;
	logic [1:0] ident_q;
	logic req;

	assign req = wb_cyc_i && wb_stb_i && !ack_q;

	function automatic logic [31:0] wmask(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int i = 0; i < 4; i++) begin
			if (s[i]) begin
				r[i*8 +: 8] = n[i*8 +: 8];
			end
		end
		return r;
	endfunction : wmask

	always_comb begin
		ctrl_d  = ctrl_q;
		f1_d    = f1_q;
		f2_d    = f2_q;
		fgain_d = fgain_q;
		rdat_d  = 32'h0000_0000;
		ack_d   = req;
		if (req && wb_we_i) begin
			case (wb_adr_i[7:0])
				ADR_CTRL:  ctrl_d = wmask(ctrl_q, wb_dat_i, wb_sel_i);
				ADR_FREQ1: f1_d = NCO_W'(wmask({8'h00, f1_q}, wb_dat_i,
					wb_sel_i));
				ADR_FREQ2: f2_d = NCO_W'(wmask({8'h00, f2_q}, wb_dat_i,
					wb_sel_i));
				ADR_GAIN:  fgain_d = GAIN_W'(wmask(32'(fgain_q), wb_dat_i,
					wb_sel_i));
				default: ;
			endcase
		end
		if (req && !wb_we_i) begin
			case (wb_adr_i[7:0])
				ADR_CTRL:  rdat_d = ctrl_q;
				ADR_FREQ1: rdat_d = 32'(f1_q);
				ADR_FREQ2: rdat_d = 32'(f2_q);
				ADR_GAIN:  rdat_d = 32'(agc_gain_o);
				ADR_STAT:  rdat_d = 32'({mono_q, valid_q, lock_q});
				ADR_ERR:   rdat_d = 32'(err_q);
				ADR_IDENT: rdat_d = 32'(ident_q);
				default:   rdat_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_q  <= CTRL_RST;
			f1_q    <= '0;
			f2_q    <= '0;
			fgain_q <= '0;
			rdat_q  <= '0;
			ack_q   <= 1'b0;
		end else if (ce_i) begin
			ctrl_q  <= ctrl_d;
			f1_q    <= f1_d;
			f2_q    <= f2_d;
			fgain_q <= fgain_d;
			rdat_q  <= rdat_d;
			ack_q   <= ack_d;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	// ----------------------------------------------------------------
	// Input select and AGC
	// ----------------------------------------------------------------
	logic [GAIN_W-1:0] gain_q, gain_d;
	logic [9:0] slow_q, slow_d;
	logic [6:0] mag;
	logic sel_q, am_q, adapt_q;

	assign mag = adc_data_i[ADC_W-1] ? ~adc_data_i[6:0] : adc_data_i[6:0];

	always_comb begin
		gain_d = gain_q;
		slow_d = slow_q;
		if (!ctrl_q[C_AGC_EN]) begin
			gain_d = fgain_q;
			slow_d = '0;
		end else if (mag >= AGC_HI) begin
			if (gain_q != GAIN_MIN) begin
				gain_d = gain_q - 1'b1;
			end
			slow_d = '0;
		end else if (mag < AGC_LO) begin
			// Rise only after long quiet period
			if (slow_q == AGC_SLOW) begin
				slow_d = '0;
				if (gain_q != GAIN_MAX) begin
					gain_d = gain_q + 1'b1;
				end
			end else begin
				slow_d = slow_q + 1'b1;
			end
		end else begin
			slow_d = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gain_q  <= '0;
			slow_q  <= '0;
			sel_q   <= 1'b0;
			am_q    <= 1'b0;
			adapt_q <= 1'b0;
		end else if (ce_i) begin
			gain_q  <= gain_d;
			slow_q  <= slow_d;
			sel_q   <= ctrl_q[C_INSEL];
			am_q    <= ctrl_q[C_AM];
			adapt_q <= ctrl_q[C_ADAPT];
		end
	end
	assign agc_gain_o        = gain_q;
	assign if_select_o       = sel_q;
	assign demod_am_o        = am_q;
	assign deemph_adaptive_o = adapt_q;

	// ----------------------------------------------------------------
	// Mixer words and carrier/timing loops
	// ----------------------------------------------------------------
	logic [NCO_W-1:0] m1_q, m2_q, trk_q, trk_d, m2_d;
	logic [7:0] tune_q, tune_d;

	always_comb begin
		trk_d = ctrl_q[C_DIG] ? trk_q + NCO_W'(signed'(carrier_err_i))
			: '0;
		m2_d  = f2_q + trk_q;
		tune_d = tune_q;
		if (dqpsk_sym_valid_i) begin
			tune_d = ctrl_q[C_TPOL] ? tune_q - 8'(timing_err_i)
				: tune_q + 8'(timing_err_i);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			m1_q   <= '0;
			m2_q   <= '0;
			trk_q  <= '0;
			tune_q <= TUNE_RST;
		end else if (ce_i) begin
			m1_q   <= f1_q;
			m2_q   <= m2_d;
			trk_q  <= trk_d;
			tune_q <= tune_d;
		end
	end
	assign mixer1_word_o              = m1_q;
	assign mixer2_word_o              = m2_q;
	assign oscillator_tuning_output_o = tune_q;

	// ----------------------------------------------------------------
	// Identification
	// ----------------------------------------------------------------
	logic [14:0] pil_q, pil_d, dual_q, dual_d, tcnt_q, tcnt_d;
	logic [1:0] ident_d;
	logic [14:0] tc_lim;

	always_comb begin
		case (ctrl_q[C_TC_LO +: 2])
			2'h0:    tc_lim = 15'(TC_FAST);
			2'h1:    tc_lim = 15'(TC_MID);
			default: tc_lim = 15'(TC_SLOW);
		endcase
		pil_d   = pil_q + 15'(pilot_tone_i);
		dual_d  = dual_q + 15'(dual_tone_i);
		tcnt_d  = tcnt_q + 1'b1;
		ident_d = ident_q;
		if (tcnt_q >= tc_lim) begin
			ident_d = {dual_q > (tc_lim >> 1), pil_q > (tc_lim >> 1)};
			pil_d   = '0;
			dual_d  = '0;
			tcnt_d  = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pil_q   <= '0;
			dual_q  <= '0;
			tcnt_q  <= '0;
			ident_q <= '0;
		end else if (ce_i) begin
			pil_q   <= pil_d;
			dual_q  <= dual_d;
			tcnt_q  <= tcnt_d;
			ident_q <= ident_d;
		end
	end

	// ----------------------------------------------------------------
	// DQPSK bit serialiser and frame decoder
	// ----------------------------------------------------------------
	tvsd_fstate_t st_q, st_d;
	logic [7:0] sh_q, sh_d;
	logic [9:0] bcnt_q, bcnt_d;
	logic [8:0] prbs_q, prbs_d;
	logic [3:0] good_q, good_d;
	logic [1:0] sym_q, sym_d;
	logic pend_q, pend_d, bit_q, bit_d, bclk_q, bclk_d;
	logic [5:0] div_q, div_d;
	logic lock_d, valid_d, mono_d, nbit, nval, dbit;

	always_comb begin
		sym_d  = sym_q;
		pend_d = pend_q;
		div_d  = div_q;
		bit_d  = bit_q;
		bclk_d = bclk_q;
		nval   = 1'b0;
		nbit   = 1'b0;
		if (dqpsk_sym_valid_i) begin
			sym_d  = dqpsk_sym_i;
			pend_d = 1'b1;
			div_d  = '0;
			nval   = 1'b1;
			nbit   = dqpsk_sym_i[1];
			bit_d  = dqpsk_sym_i[1];
			bclk_d = 1'b0;
		end else if (div_q == 6'(BIT_DIV / 2 - 1)) begin
			bclk_d = 1'b1;
			div_d  = div_q + 1'b1;
		end else if (div_q == 6'(BIT_DIV - 1) && pend_q) begin
			pend_d = 1'b0;
			nval   = 1'b1;
			nbit   = sym_q[0];
			bit_d  = sym_q[0];
			bclk_d = 1'b0;
			div_d  = '0;
		end else if (div_q != 6'h3F) begin
			// Counter restarts per bit, one mid-bit compare serves both
			div_d  = div_q + 1'b1;
		end
	end

	always_comb begin
		st_d    = st_q;
		sh_d    = sh_q;
		bcnt_d  = bcnt_q;
		prbs_d  = prbs_q;
		good_d  = good_q;
		lock_d  = lock_q;
		valid_d = valid_q;
		mono_d  = mono_q;
		dbit    = nbit ^ prbs_q[0];
		if (nval) begin
			sh_d   = {sh_q[6:0], nbit};
			bcnt_d = bcnt_q + 1'b1;
			prbs_d = {prbs_q[4] ^ prbs_q[0], prbs_q[8:1]};
			case (st_q)
				TVSD_HUNT: begin
					if ({sh_q[6:0], nbit} == FAW) begin
						st_d   = TVSD_SYNC;
						bcnt_d = '0;
						prbs_d = PRBS_SEED;
						good_d = '0;
					end
				end
				TVSD_SYNC, TVSD_LOCKED: begin
					if (bcnt_q == 10'(FRAME_BITS - 1)) begin
						bcnt_d = '0;
						prbs_d = PRBS_SEED;
						if ({sh_q[6:0], nbit} == FAW) begin
							if (good_q == LOCK_NEED) begin
								st_d = TVSD_LOCKED;
							end else begin
								good_d = good_q + 1'b1;
							end
						end else begin
							st_d   = TVSD_HUNT;
							good_d = '0;
						end
					end else if (bcnt_q == 10'h000) begin
						valid_d = (st_q == TVSD_LOCKED) && !dbit;
					end else if (bcnt_q == 10'h004) begin
						mono_d = dbit;
					end
				end
				default: st_d = TVSD_HUNT;
			endcase
		end
		lock_d = (st_d == TVSD_LOCKED);
		if (!lock_d) begin
			valid_d = 1'b0;
			mono_d  = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q    <= TVSD_HUNT;
			sh_q    <= '0;
			bcnt_q  <= '0;
			prbs_q  <= PRBS_SEED;
			good_q  <= '0;
			lock_q  <= 1'b0;
			valid_q <= 1'b0;
			mono_q  <= 1'b0;
			sym_q   <= '0;
			pend_q  <= 1'b0;
			div_q   <= '0;
			bit_q   <= 1'b0;
			bclk_q  <= 1'b0;
		end else if (ce_i) begin
			st_q    <= st_d;
			sh_q    <= sh_d;
			bcnt_q  <= bcnt_d;
			prbs_q  <= prbs_d;
			good_q  <= good_d;
			lock_q  <= lock_d;
			valid_q <= valid_d;
			mono_q  <= mono_d;
			sym_q   <= sym_d;
			pend_q  <= pend_d;
			div_q   <= div_d;
			bit_q   <= bit_d;
			bclk_q  <= bclk_d;
		end
	end
	assign digital_sound_serial_out_o = bit_q;
	assign bit_clock_o                = bclk_q;

	// ----------------------------------------------------------------
	// Parity error window count
	// ----------------------------------------------------------------
	logic [31:0] win_q, win_d;
	logic [7:0] acc_q, acc_d, err_d;

	always_comb begin
		win_d = win_q + 1'b1;
		acc_d = acc_q;
		err_d = err_q;
		if (parity_err_i && lock_q && acc_q != ERR_MAX) begin
			acc_d = acc_q + 1'b1;
		end
		if (win_q == 32'(WIN_CYCLES - 1)) begin
			win_d = '0;
			err_d = acc_d;
			acc_d = '0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			win_q <= '0;
			acc_q <= '0;
			err_q <= '0;
		end else if (ce_i) begin
			win_q <= win_d;
			acc_q <= acc_d;
			err_q <= err_d;
		end
	end
endmodule : tvsd_core
`default_nettype wire

// ---- tb/tvsd_checker.sv ----
// Purpose: Port checks on the sound decoder core
// Assumes: ce_i low only while the bus and stream are idle
// Notes:   Bound into tvsd_core
`timescale 1ns/100ps
`default_nettype none
module tvsd_checker
	import tvsd_pkg::*;
#(
	parameter int unsigned WIN_CYCLES = 1000
) (
	input wire logic              clk_i,
	input wire logic              rst_i,
	input wire logic              ce_i,
	input wire logic [31:0]       wb_adr_i,
	input wire logic [31:0]       wb_dat_o,
	input wire logic              wb_we_i,
	input wire logic              wb_cyc_i,
	input wire logic              wb_stb_i,
	input wire logic              wb_ack_o,
	input wire logic              if_select_o,
	input wire logic              demod_am_o,
	input wire logic [NCO_W-1:0]  mixer1_word_o,
	input wire logic [1:0]        dqpsk_sym_i,
	input wire logic              dqpsk_sym_valid_i,
	input wire logic              digital_sound_serial_out_o,
	input wire logic              bit_clock_o,
	input wire logic [7:0]        oscillator_tuning_output_o
);
	logic       take;
	logic       rd_ack;
	logic       wr_req;
	logic [7:0] a8;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
	assign rd_ack = wb_ack_o && !wb_we_i;
	assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i;
	assign a8 = wb_adr_i[7:0];
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// ---------
	// Assertions
	// ---------
	property p_bits;
		logic [1:0] s;
		(dqpsk_sym_valid_i, s = dqpsk_sym_i) |=>
			digital_sound_serial_out_o == s[1]
			##54 digital_sound_serial_out_o == s[0];
	endproperty
	a_ack_after_take: assert property (take |=> wb_ack_o)
		else $error("no ack after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	a_unmapped_zero: assert property (take && !wb_we_i && a8 >= 8'h1C
		|=> wb_dat_o == 32'h0) else $error("unmapped read not zero");
	a_word_upper_zero: assert property (
		rd_ack && (a8 == ADR_FREQ1 || a8 == ADR_FREQ2)
		|-> wb_dat_o[31:24] == 8'h00) else $error("word upper byte set");
	a_valid_needs_lock: assert property (
		rd_ack && a8 == ADR_STAT
		|-> !wb_dat_o[S_VALID] || wb_dat_o[S_LOCK])
		else $error("valid without lock");
	a_insel_by_write: assert property (
		$changed(if_select_o) |-> $past(wr_req))
		else $error("input select moved without write");
	a_am_by_write: assert property (
		$changed(demod_am_o) |-> $past(wr_req))
		else $error("demod mode moved without write");
	a_mixer1_by_write: assert property (
		$changed(mixer1_word_o) |-> $past(wr_req))
		else $error("mixer word moved without write");
	a_bit_order: assert property (p_bits)
		else $error("serial bit order wrong");
	a_bclk_mid_bit: assert property (
		dqpsk_sym_valid_i |=> !bit_clock_o ##27 bit_clock_o)
		else $error("bit clock not high mid-bit");
	a_tune_at_reset: assert property (
		$fell(rst_i) |-> oscillator_tuning_output_o == 8'h80)
		else $error("tuning not centred after reset");
	c_write: cover property (take && wb_we_i);
	c_symbol: cover property (dqpsk_sym_valid_i);
	c_bitclk: cover property ($rose(bit_clock_o));
endmodule : tvsd_checker
bind tvsd_core tvsd_checker #(.WIN_CYCLES(WIN_CYCLES)) i_chk (.clk_i,
	.rst_i, .ce_i, .wb_adr_i, .wb_dat_o, .wb_we_i, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .if_select_o, .demod_am_o, .mixer1_word_o, .dqpsk_sym_i,
	.dqpsk_sym_valid_i, .digital_sound_serial_out_o, .bit_clock_o,
	.oscillator_tuning_output_o);
`default_nettype wire

// ---- tb/tvsd_host.sv ----
// Purpose: Host model issuing classic Wishbone cycles
// Assumes: Slave answers within 20 cycles
// Notes:   Idle cycle between requests
`timescale 1ns/100ps
`default_nettype none
module tvsd_host (
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] adr_o,
	output logic      [31:0] dat_o,
	output logic             we_o,
	output logic      [3:0]  sel_o,
	output logic             cyc_o,
	output logic             stb_o
);
	initial begin
		adr_o = 32'h0;
		dat_o = 32'h0;
		we_o = 1'h0;
		sel_o = 4'hF;
		cyc_o = 1'h0;
		stb_o = 1'h0;
	end
	task automatic xfer(input logic w, input logic [31:0] a, d,
		output logic [31:0] q, output logic ok);
		int n;
		n = 0;
		@(posedge clk_i);
		adr_o <= a;
		dat_o <= d;
		we_o <= w;
		cyc_o <= 1'h1;
		stb_o <= 1'h1;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_i !== 1'h1 && n < 20);
		ok = (ack_i === 1'h1);
		q = dat_i;
		cyc_o <= 1'h0;
		stb_o <= 1'h0;
		we_o <= 1'h0;
	endtask : xfer
endmodule : tvsd_host
`default_nettype wire

// ---- tb/tb_top.sv ----
// Purpose: Register and stream tests of the sound decoder core
// Assumes: Short error window of 1000 cycles
// Notes:   Decoder never locks in these runs
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import tvsd_pkg::*;
	logic clk_i, rst_i, ce_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
	logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, q;
	logic [3:0] wb_sel_i;
	logic [7:0] adc_data_i, oscillator_tuning_output_o;
	logic [4:0] agc_gain_o, g;
	logic [23:0] mixer1_word_o, mixer2_word_o;
	logic [1:0] dqpsk_sym_i;
	logic signed [7:0] carrier_err_i, timing_err_i;
	logic if_select_o, demod_am_o, deemph_adaptive_o, dqpsk_sym_valid_i;
	logic pilot_tone_i, dual_tone_i, parity_err_i;
	logic digital_sound_serial_out_o, bit_clock_o;
	int bad_count = 0;
	int tests_run = 0;
	tvsd_core #(.WIN_CYCLES(1000)) i_dut (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(ce_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_ack_o(wb_ack_o), .adc_data_i(adc_data_i),
		.if_select_o(if_select_o), .agc_gain_o(agc_gain_o),
		.mixer1_word_o(mixer1_word_o),
		.mixer2_word_o(mixer2_word_o), .demod_am_o(demod_am_o),
		.deemph_adaptive_o(deemph_adaptive_o),
		.dqpsk_sym_i(dqpsk_sym_i),
		.dqpsk_sym_valid_i(dqpsk_sym_valid_i),
		.carrier_err_i(carrier_err_i), .timing_err_i(timing_err_i),
		.pilot_tone_i(pilot_tone_i), .dual_tone_i(dual_tone_i),
		.parity_err_i(parity_err_i),
		.digital_sound_serial_out_o(digital_sound_serial_out_o),
		.bit_clock_o(bit_clock_o),
		.oscillator_tuning_output_o(oscillator_tuning_output_o));
	tvsd_host i_host (.clk_i(clk_i), .ack_i(wb_ack_o), .dat_i(wb_dat_o),
		.adr_o(wb_adr_i), .dat_o(wb_dat_i), .we_o(wb_we_i),
		.sel_o(wb_sel_i), .cyc_o(wb_cyc_i), .stb_o(wb_stb_i));
	initial begin
		clk_i = 1'h0;
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic stop_test();
		$display("compares %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		logic ok;
		i_host.xfer(w, {24'h0, a}, d, q, ok);
		if (ok !== 1'h1) begin
			bad_count++;
			$display("MISMATCH %0t bus timeout", $time);
			stop_test();
		end
	endtask : bus
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		bus(1'h0, a, 32'h0);
		chk(q, exp);
	endtask : rdc
	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : wait_clk
	// ---------
	// Main sequence
	// ---------
	initial begin
		rst_i = 1'h1;
		ce_i = 1'h1;
		adc_data_i = 8'h00;
		dqpsk_sym_i = 2'h0;
		dqpsk_sym_valid_i = 1'h0;
		carrier_err_i = 8'sh00;
		timing_err_i = 8'sh00;
		pilot_tone_i = 1'h0;
		dual_tone_i = 1'h0;
		parity_err_i = 1'h0;
		wait_clk(5);
		rst_i <= 1'h0;
		wait_clk(1);
		chk(32'(oscillator_tuning_output_o), 32'h80);
		rdc(ADR_CTRL, CTRL_RST);
		rdc(8'h1C, 32'h0);
		rdc(ADR_STAT, 32'h0);
		$display("test reset done");
		bus(1'h1, ADR_CTRL, 32'h15);
		bus(1'h1, ADR_GAIN, 32'h0A);
		wait_clk(1);
		chk(32'({if_select_o, demod_am_o, deemph_adaptive_o}), 32'h7);
		chk(32'(agc_gain_o), 32'h0A);
		for (int s = 0; s < 3; s++) begin
			logic [31:0] v;
			v = 32'h15 | (32'(s) << 6) | (32'(s) << 8);
			bus(1'h1, ADR_CTRL, v);
			rdc(ADR_CTRL, v);
		end
		$display("test controls done");
		carrier_err_i <= 8'sh10;
		bus(1'h1, ADR_FREQ1, 32'hFF12_3456);
		bus(1'h1, ADR_FREQ2, 32'hFF65_4321);
		wait_clk(20);
		chk(32'(mixer1_word_o), 32'h0012_3456);
		chk(32'(mixer2_word_o), 32'h0065_4321);
		rdc(ADR_FREQ1, 32'h0012_3456);
		bus(1'h1, ADR_CTRL, 32'h1D);
		wait_clk(20);
		chk(32'(mixer2_word_o != 24'h65_4321), 32'h1);
		$display("test mixers done");
		bus(1'h1, ADR_CTRL, 32'h02);
		wait_clk(2100);
		g = agc_gain_o;
		// Clock enable low must freeze the loop
		ce_i <= 1'h0;
		adc_data_i <= 8'h7F;
		wait_clk(30);
		chk(32'(agc_gain_o), 32'(g));
		ce_i <= 1'h1;
		wait_clk(30);
		chk(32'(agc_gain_o < g), 32'h1);
		g = agc_gain_o;
		adc_data_i <= 8'h50;
		wait_clk(1200);
		chk(32'(agc_gain_o), 32'(g));
		adc_data_i <= 8'h00;
		wait_clk(200);
		chk(32'(agc_gain_o), 32'(g));
		wait_clk(1000);
		chk(32'(agc_gain_o > g), 32'h1);
		$display("test gain loop done");
		for (int i = 0; i < 4; i++) begin
			dqpsk_sym_i <= 2'(i);
			dqpsk_sym_valid_i <= 1'h1;
			wait_clk(1);
			dqpsk_sym_valid_i <= 1'h0;
			chk(32'(digital_sound_serial_out_o), 32'((i >> 1) & 1));
			wait_clk(int'(BIT_DIV / 2) - 1);
			chk(32'(bit_clock_o), 32'h0);
			wait_clk(1);
			chk(32'(bit_clock_o), 32'h1);
			wait_clk(int'(BIT_DIV / 2));
			chk(32'(digital_sound_serial_out_o), 32'(i & 1));
			chk(32'(bit_clock_o), 32'h0);
			wait_clk(60);
		end
		$display("test stream done");
		// Loop steps once per symbol, sign set by polarity bit
		timing_err_i <= 8'sh20;
		dqpsk_sym_valid_i <= 1'h1;
		wait_clk(1);
		dqpsk_sym_valid_i <= 1'h0;
		wait_clk(60);
		chk(32'(oscillator_tuning_output_o), 32'hA0);
		bus(1'h1, ADR_CTRL, 32'h22);
		dqpsk_sym_valid_i <= 1'h1;
		wait_clk(1);
		dqpsk_sym_valid_i <= 1'h0;
		timing_err_i <= 8'sh00;
		wait_clk(60);
		chk(32'(oscillator_tuning_output_o), 32'h80);
		$display("test tuning done");
		pilot_tone_i <= 1'h1;
		parity_err_i <= 1'h1;
		wait_clk(17000);
		rdc(ADR_IDENT, 32'h1);
		rdc(ADR_ERR, 32'h0);
		// Host error-rate estimate, scaled to an integer
		chk(q * 32'h0000_00AE, 32'h0);
		rdc(ADR_STAT, 32'h0);
		$display("test status done");
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
